// ===== src/vsp_params.svh
// Port addresses, field positions and reset values for the status and palette port block.
// Assumes a 16-bit host I/O address and byte-wide host data.
//
// Contract
// - Feature control written at status port, read at 3CA; status port reads display status.
// - Sync select bit set makes vertical sync output the OR with display enable.
// - Feature control bits 1 and 0 drive feature connector pins 1 and 0.
// - Input status zero bit 7 reads 1 while a frame interrupt is pending.
// - Frame interrupt held clear by clear control, set a line after display enable.
// - Interrupt disable forces pending bit to 0; bit shows flip-flop, not request line.
// - Input status zero bits 6-5 return the two feature code inputs.
// - Input status zero bit 4 returns the monitor sense pin level.
// - Reading display status forces attribute index/data toggle to index state.
// - Display status bit 7 is not-vertical-retrace on revision 4 and later, else 0.
// - Display status bit 3 reads 1 during vertical retrace.
// - Display status bits 5-4 return attribute output pair chosen by diagnostic select.
// - In wide colour mode diagnostic bits sample the intermediate nibble outputs.
// - Pen switch bit 2 reads 1, pen trigger bit 1 reads 0.
// - Display status bit 0 reads 1 during any retrace, 0 while displaying.
// - Pixel mask is ANDed with video data entering the palette.
// - Palette state captures address low bits of last write to 3C6-3C9.
// - Reading 3C7 suppresses palette decode and returns the palette state.
// - Palette holds 256 entries of 18 bits, transferred red, green, blue.
// - Read index write saves index and increments; after third byte reload and increment.
// - Writing either index port restarts the byte sequence at red.
// - Index reads back only at the write-mode index port.
`ifndef VSP_PARAMS_SVH
`define VSP_PARAMS_SVH

`define VSP_PORT_IS0 16'h03c2
`define VSP_PORT_FC_RD 16'h03ca
`define VSP_PORT_STAT_MONO 16'h03ba
`define VSP_PORT_STAT_COLOR 16'h03da
`define VSP_PORT_MASK 16'h03c6
`define VSP_PORT_RIDX 16'h03c7
`define VSP_PORT_WIDX 16'h03c8
`define VSP_PORT_DATA 16'h03c9

`define VSP_FC_USED 8'h0b
`define VSP_FC_VSYNC_SEL 3
`define VSP_FC_RESET 8'h00
`define VSP_MASK_RESET 8'h00
`define VSP_PSTATE_RESET 2'h0
`define VSP_REV_NOT_VR 4
`define VSP_PAL_ENTRIES 256

`endif

// ===== src/vsp_pkg.sv
// Types shared by the status and palette port modules.
// Assumes the constants header is included by each user.
package vsp_pkg;
	typedef enum logic [1:0] {SEQ_RED, SEQ_GREEN, SEQ_BLUE} vsp_seq_t;
	typedef enum logic {MODE_WRITE, MODE_READ} vsp_mode_t;

	typedef struct packed {
		logic [7:0] index;
		logic [7:0] save;
		vsp_seq_t seq;
		vsp_mode_t mode;
		logic [5:0] red;
		logic [5:0] green;
		logic [17:0] rgb;
	} vsp_pal_state_t;

	typedef struct packed {
		logic [7:0] fc;
		logic [7:0] mask;
		logic [1:0] pstate;
		logic frame_ff;
		logic line_armed;
		logic vde_d;
		logic hsync_d;
		logic [7:0] rdata;
		logic rvalid;
		logic atc_reset;
		logic suppress;
		logic vsync_out;
		logic [1:0] fc_pins;
		logic [7:0] pixel;
	} vsp_top_state_t;
endpackage

// ===== src/vsp_pal_if.sv
// Carrier between the port decoder and the palette store.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface vsp_pal_if;
	logic idx_wr_read;
	logic idx_wr_write;
	logic data_wr;
	logic data_rd;
	logic [7:0] wdata;
	logic [7:0] pixel;
	logic [7:0] index;
	logic [7:0] rdata;
	logic [17:0] rgb;

	modport host (
		output idx_wr_read, idx_wr_write, data_wr, data_rd, wdata, pixel,
		input index, rdata, rgb
	);
	modport pal (
		input idx_wr_read, idx_wr_write, data_wr, data_rd, wdata, pixel,
		output index, rdata, rgb
	);
endinterface

// ===== src/vsp_sync2.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; multi-bit words may show mixed samples.
`timescale 1ns/10ps
module vsp_sync2 #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} vsp_sync_t;

	vsp_sync_t st_reg;
	vsp_sync_t st_next;

	always_comb begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule

// ===== src/vsp_palette.sv
// Colour palette store with index, save register and red-green-blue sequencing.
// Assumes single-cycle access strobes from the port decoder on the same clock.
`timescale 1ns/10ps
`include "vsp_params.svh"
module vsp_palette (
	input wire logic sys_clk,
	input wire logic srst,
	vsp_pal_if.pal bus
);
	logic [17:0] mem [0:`VSP_PAL_ENTRIES-1];
	vsp_pkg::vsp_pal_state_t st_reg;
	vsp_pkg::vsp_pal_state_t st_next;
	logic mem_we;
	logic [17:0] entry;

	always_comb begin
		st_next = st_reg;
		mem_we = 1'b0;
		entry = mem[(st_reg.mode == vsp_pkg::MODE_READ) ? st_reg.save : st_reg.index];
		st_next.rgb = mem[bus.pixel];
		if (bus.idx_wr_write) begin
			st_next.index = bus.wdata;
			st_next.mode = vsp_pkg::MODE_WRITE;
			st_next.seq = vsp_pkg::SEQ_RED;
		end else if (bus.idx_wr_read) begin
			st_next.save = bus.wdata;
			st_next.index = bus.wdata + 8'h01;
			st_next.mode = vsp_pkg::MODE_READ;
			st_next.seq = vsp_pkg::SEQ_RED;
		end else if (bus.data_wr && st_reg.mode == vsp_pkg::MODE_WRITE) begin
			case (st_reg.seq)
				vsp_pkg::SEQ_RED: begin
					st_next.red = bus.wdata[5:0];
					st_next.seq = vsp_pkg::SEQ_GREEN;
				end
				vsp_pkg::SEQ_GREEN: begin
					st_next.green = bus.wdata[5:0];
					st_next.seq = vsp_pkg::SEQ_BLUE;
				end
				default: begin
					mem_we = 1'b1;
					st_next.index = st_reg.index + 8'h01;
					st_next.seq = vsp_pkg::SEQ_RED;
				end
			endcase
		end else if (bus.data_rd && st_reg.mode == vsp_pkg::MODE_READ) begin
			case (st_reg.seq)
				vsp_pkg::SEQ_RED: begin
					st_next.seq = vsp_pkg::SEQ_GREEN;
				end
				vsp_pkg::SEQ_GREEN: begin
					st_next.seq = vsp_pkg::SEQ_BLUE;
				end
				default: begin
					st_next.save = st_reg.index;
					st_next.index = st_reg.index + 8'h01;
					st_next.seq = vsp_pkg::SEQ_RED;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// The array has no reset; its contents are undefined until software loads it.
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			mem[st_reg.index] <= {st_reg.red, st_reg.green, bus.wdata[5:0]};
		end
	end

	always_comb begin
		case (st_reg.seq)
			vsp_pkg::SEQ_RED: bus.rdata = {2'h0, entry[17:12]};
			vsp_pkg::SEQ_GREEN: bus.rdata = {2'h0, entry[11:6]};
			default: bus.rdata = {2'h0, entry[5:0]};
		endcase
	end

	assign bus.index = st_reg.index;
	assign bus.rgb = st_reg.rgb;
endmodule

// ===== src/vsp_top.sv
// Miscellaneous status ports, feature control and palette ports of the display controller.
// Assumes one-cycle host read and write strobes on sys_clk and video pins from other clocks.
`timescale 1ns/10ps
`include "vsp_params.svh"
module vsp_top #(
	parameter int CHIP_REV = 4
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic io_rdata_valid,
	output logic palette_decode_suppress,
	output logic atc_index_reset,
	input wire logic crtc_color_sel,
	input wire logic int_clear_n,
	input wire logic int_disable,
	input wire logic [1:0] color_plane_diag_select,
	input wire logic wide_color_mux_enable,
	input wire logic vsync_in,
	input wire logic hsync_in,
	input wire logic vde_in,
	input wire logic vretrace_in,
	input wire logic display_active_in,
	input wire logic monitor_sense_in,
	input wire logic [1:0] feature_code_in,
	input wire logic [7:0] video_output_pins,
	input wire logic [7:0] atc_nibble_mux_in,
	output logic vsync_out,
	output logic [1:0] feature_control_pins,
	output logic [17:0] palette_rgb
);
	// -----------------------------------------------------------------
	// Synchronised inputs
	// -----------------------------------------------------------------
	logic vsync_s;
	logic hsync_s;
	logic vde_s;
	logic vr_s;
	logic act_s;
	logic sense_s;
	logic [1:0] fcode_s;
	logic [7:0] pix_s;
	logic [7:0] nib_s;

	// Each pin group has its own synchroniser so that timing groups can be placed apart.
	vsp_sync2 #(
		.W(1)
	) vsync_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(vsync_in),
		.q(vsync_s)
	);

	vsp_sync2 #(
		.W(1)
	) hsync_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(hsync_in),
		.q(hsync_s)
	);

	vsp_sync2 #(
		.W(1)
	) vde_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(vde_in),
		.q(vde_s)
	);

	vsp_sync2 #(
		.W(1)
	) vretrace_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(vretrace_in),
		.q(vr_s)
	);

	vsp_sync2 #(
		.W(1)
	) active_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(display_active_in),
		.q(act_s)
	);

	vsp_sync2 #(
		.W(1)
	) sense_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(monitor_sense_in),
		.q(sense_s)
	);

	// The feature code bits are static straps, so a mixed sample of the pair is harmless.
	vsp_sync2 #(
		.W(2)
	) fcode_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(feature_code_in),
		.q(fcode_s)
	);

	// The pixel word is only sampled for diagnostics and lookup, never decoded as a count.
	vsp_sync2 #(
		.W(8)
	) pixel_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(video_output_pins),
		.q(pix_s)
	);

	vsp_sync2 #(
		.W(8)
	) nibble_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(atc_nibble_mux_in),
		.q(nib_s)
	);

	// -----------------------------------------------------------------
	// Palette store
	// -----------------------------------------------------------------
	vsp_pal_if pal_bus ();

	vsp_palette u_pal (
		.sys_clk(sys_clk),
		.srst(srst),
		.bus(pal_bus.pal)
	);

	// -----------------------------------------------------------------
	// Port decode
	// -----------------------------------------------------------------
	vsp_pkg::vsp_top_state_t st_reg;
	vsp_pkg::vsp_top_state_t st_next;
	logic [15:0] stat_port;
	logic in_pal_range;
	logic pending;
	logic [7:0] diag_src;
	logic [1:0] diag;
	logic [7:0] rd_mux;
	logic rd_hit;
	logic [7:0] is0_word;
	logic [7:0] stat_word;
	logic not_vr;

	assign stat_port = crtc_color_sel ? `VSP_PORT_STAT_COLOR : `VSP_PORT_STAT_MONO;
	assign in_pal_range = (io_addr >= `VSP_PORT_MASK) && (io_addr <= `VSP_PORT_DATA);
	assign pending = st_reg.frame_ff & ~int_disable;

	assign pal_bus.idx_wr_read = io_wr && (io_addr == `VSP_PORT_RIDX);
	assign pal_bus.idx_wr_write = io_wr && (io_addr == `VSP_PORT_WIDX);
	assign pal_bus.data_wr = io_wr && (io_addr == `VSP_PORT_DATA);
	assign pal_bus.data_rd = io_rd && (io_addr == `VSP_PORT_DATA);
	assign pal_bus.wdata = io_wdata;
	assign pal_bus.pixel = st_reg.pixel;

	// The intermediate nibbles alternate position each dot clock, so a status read sees
	// whichever half happened to be sampled; software must read repeatedly to see both.
	assign diag_src = wide_color_mux_enable ? nib_s : pix_s;

	always_comb begin
		case (color_plane_diag_select)
			2'h0: diag = {diag_src[2], diag_src[0]};
			2'h1: diag = {diag_src[5], diag_src[4]};
			2'h2: diag = {diag_src[3], diag_src[1]};
			default: diag = {diag_src[7], diag_src[6]};
		endcase
	end

	// -----------------------------------------------------------------
	// Status words
	// -----------------------------------------------------------------
	// Older revisions tie the inverted retrace bit low, so software must not rely on it.
	assign not_vr = (CHIP_REV >= `VSP_REV_NOT_VR) ? ~vr_s : 1'b0;
	assign is0_word = {pending, fcode_s, sense_s, 4'h0};
	assign stat_word = {not_vr, 1'b0, diag, vr_s, 1'b1, 1'b0, ~act_s};

	// -----------------------------------------------------------------
	// Read data selection
	// -----------------------------------------------------------------
	always_comb begin
		rd_hit = 1'b1;
		if (io_addr == `VSP_PORT_IS0) begin
			rd_mux = is0_word;
		end else if (io_addr == stat_port) begin
			rd_mux = stat_word;
		end else if (io_addr == `VSP_PORT_FC_RD) begin
			rd_mux = st_reg.fc & `VSP_FC_USED;
		end else if (io_addr == `VSP_PORT_MASK) begin
			rd_mux = st_reg.mask;
		end else if (io_addr == `VSP_PORT_RIDX) begin
			rd_mux = {6'h00, st_reg.pstate};
		end else if (io_addr == `VSP_PORT_WIDX) begin
			rd_mux = pal_bus.index;
		end else if (io_addr == `VSP_PORT_DATA) begin
			rd_mux = pal_bus.rdata;
		end else begin
			rd_mux = 8'h00;
			rd_hit = 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// State update
	// -----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.vde_d = vde_s;
		st_next.hsync_d = hsync_s;
		st_next.rvalid = io_rd & rd_hit;
		st_next.atc_reset = io_rd && (io_addr == stat_port);
		st_next.suppress = io_rd && (io_addr == `VSP_PORT_RIDX);
		if (io_rd) begin
			st_next.rdata = rd_mux;
		end
		if (io_wr && io_addr == stat_port) begin
			st_next.fc = io_wdata & `VSP_FC_USED;
		end
		if (io_wr && io_addr == `VSP_PORT_MASK) begin
			st_next.mask = io_wdata;
		end
		if (io_wr && in_pal_range) begin
			st_next.pstate = io_addr[1:0];
		end
		// A scan line after display enable drops, the next horizontal sync sets the flag.
		if (st_reg.vde_d && !vde_s) begin
			st_next.line_armed = 1'b1;
		end else if (st_reg.line_armed && hsync_s && !st_reg.hsync_d) begin
			st_next.line_armed = 1'b0;
			st_next.frame_ff = 1'b1;
		end
		if (!int_clear_n) begin
			st_next.frame_ff = 1'b0;
			st_next.line_armed = 1'b0;
		end
		st_next.vsync_out = st_reg.fc[`VSP_FC_VSYNC_SEL] ? (vsync_s | vde_s) : vsync_s;
		st_next.fc_pins = st_reg.fc[1:0];
		st_next.pixel = pix_s & st_reg.mask;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.fc <= `VSP_FC_RESET;
			st_reg.mask <= `VSP_MASK_RESET;
			st_reg.pstate <= `VSP_PSTATE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign io_rdata = st_reg.rdata;
	assign io_rdata_valid = st_reg.rvalid;
	assign palette_decode_suppress = st_reg.suppress;
	assign atc_index_reset = st_reg.atc_reset;
	assign vsync_out = st_reg.vsync_out;
	assign feature_control_pins = st_reg.fc_pins;
	assign palette_rgb = pal_bus.rgb;
endmodule

// ===== tb/vsp_top_properties.sv
// Port-level checks on the status and palette port block.
// Assumes binding to vsp_top and sight of its ports only.
`timescale 1ns/10ps
module vsp_top_properties #(
	parameter int CHIP_REV = 4
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic crtc_color_sel,
	input wire logic int_disable,
	input wire logic int_clear_n,
	input wire logic [7:0] io_rdata,
	input wire logic io_rdata_valid,
	input wire logic palette_decode_suppress,
	input wire logic atc_index_reset,
	input wire logic [1:0] feature_control_pins
);
	// ----
	// Checks
	// ----
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	wire logic [15:0] stat_port = crtc_color_sel ? 16'h03da : 16'h03ba;
	wire logic stat_rd = io_rd && io_addr == stat_port;
	wire logic is0_rd = io_rd && io_addr == 16'h03c2;
	a_stat_fixed_bits: assert property (stat_rd |=> atc_index_reset && io_rdata_valid
		&& io_rdata[6] == 1'b0 && io_rdata[2:1] == 2'b10) else $error("stat read bad");
	a_stat_retrace_pair: assert property (stat_rd |=> (CHIP_REV >= 4 ?
		io_rdata[7] == !io_rdata[3] : !io_rdata[7])) else $error("retrace bits bad");
	a_state_substitute: assert property (io_rd && io_addr == 16'h03c7 |=>
		palette_decode_suppress && io_rdata[7:2] == 6'h00) else $error("state read bad");
	a_fc_readback: assert property (io_rd && io_addr == 16'h03ca && !$past(io_wr) |=>
		io_rdata[7:4] == 4'h0 && !io_rdata[2] && io_rdata[1:0] == feature_control_pins)
		else $error("fc readback bad");
	a_unmapped_quiet: assert property (io_rd && io_addr == 16'h0300 |=>
		!io_rdata_valid && io_rdata == 8'h00) else $error("unmapped read answered");
	a_strobes_idle: assert property (!io_rd |=> !io_rdata_valid && !atc_index_reset
		&& !palette_decode_suppress) else $error("stray read pulse");
	a_pend_masked: assert property (int_disable && $past(int_disable) && is0_rd |=>
		io_rdata_valid && !io_rdata[7] && io_rdata[3:0] == 4'h0) else $error("pend unmasked");
	a_pend_held_clear: assert property ((!int_clear_n)[*3] ##0 is0_rd |=>
		!io_rdata[7]) else $error("flag not held clear");
endmodule
bind vsp_top vsp_top_properties #(.CHIP_REV(CHIP_REV)) vsp_top_properties_inst (.*);

// ===== tb/vsp_host_model.sv
// Host processor model issuing single I/O reads and writes.
// Assumes one-cycle strobes and answers registered on the taking edge.
`timescale 1ns/10ps
module vsp_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] io_rdata,
	input wire logic io_rdata_valid,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata
);
	// ----
	// Bus cycles
	// ----
	initial begin
		{io_addr, io_wr, io_rd, io_wdata} = '0;
	end
	// Released lines show the inverse so stale values never look valid.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		io_wr = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(posedge sys_clk);
		#1;
		io_addr = a;
		io_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		io_rd = 1'b0;
		io_addr = ~a;
		d = io_rdata;
		v = io_rdata_valid;
	endtask
	task automatic rd3(output logic [17:0] c);
		logic [7:0] b;
		logic v;
		for (int k = 0; k < 3; k++) begin
			rd(16'h03c9, b, v);
			c = {c[11:0], b[5:0]};
		end
	endtask
endmodule

// ===== tb/vsp_top_tb_top.sv
// Self-checking bench for the status and palette port block.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/10ps
module vsp_top_tb_top;
	logic sys_clk, srst, io_wr, io_rd, io_rdata_valid, palette_decode_suppress;
	logic atc_index_reset, crtc_color_sel, int_clear_n, int_disable, wide_color_mux_enable;
	logic vsync_in, hsync_in, vde_in, vretrace_in, display_active_in, monitor_sense_in;
	logic vsync_out, v;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata, video_output_pins, atc_nibble_mux_in, d, ex, s;
	logic [7:0] pb [6];
	logic [1:0] color_plane_diag_select, feature_code_in, feature_control_pins;
	logic [17:0] palette_rgb, e0, e1, e;
	logic [31:0] lfsr;
	int err_total, tests_run;
	vsp_top #(.CHIP_REV(4)) vsp_top_inst (.*);
	vsp_host_model vsp_host_model_inst (.*);
	// ----
	// Helpers
	// ----
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction
	function automatic logic [7:0] stat_exp(logic vr, logic act, logic [1:0] sel, logic [7:0] p);
		logic [1:0] q;
		q = sel == 2'h0 ? {p[2], p[0]} : sel == 2'h1 ? {p[5], p[4]} :
			sel == 2'h2 ? {p[3], p[1]} : {p[7], p[6]};
		return {!vr, 1'b0, q, vr, 1'b1, 1'b0, !act};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] x);
		vsp_host_model_inst.rd(a, d, v);
		chk({v, d}, {1'b1, x});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic complete_run();
		if (err_total == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		complete_run();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		lfsr = 32'h49c4;
		{int_disable, wide_color_mux_enable, vsync_in, hsync_in, vde_in, vretrace_in} = '0;
		{monitor_sense_in, video_output_pins, atc_nibble_mux_in, color_plane_diag_select} = '0;
		{srst, crtc_color_sel, int_clear_n, display_active_in, feature_code_in} = '1;
		idle(3);
		srst = 1'b0;
		rchk(16'h03ca, 8'h00);
		rchk(16'h03c6, 8'h00);
		rchk(16'h03c7, 8'h00);
		for (int i = 0; i < 4; i++) begin
			ex = rnd();
			crtc_color_sel = ex[7];
			vsp_host_model_inst.wr(ex[7] ? 16'h03da : 16'h03ba, ex);
			vsp_host_model_inst.wr(ex[7] ? 16'h03ba : 16'h03da, ~ex);
			rchk(16'h03ca, ex & 8'h0b);
			chk(feature_control_pins, ex[1:0]);
		end
		crtc_color_sel = 1'b1;
		for (int i = 0; i < 8; i++) begin
			{vsync_in, vde_in} = {i[1], i[0]};
			vsp_host_model_inst.wr(16'h03da, {4'h0, i[2], 3'h0});
			idle(4);
			chk(vsync_out, i[1] | (i[2] & i[0]));
		end
		for (int i = 0; i < 4; i++) begin
			ex = rnd();
			{feature_code_in, monitor_sense_in} = ex[2:0];
			idle(3);
			rchk(16'h03c2, {1'b0, ex[2:0], 4'h0});
		end
		vde_in = 1'b1;
		idle(4);
		vde_in = 1'b0;
		idle(4);
		hsync_in = 1'b1;
		idle(4);
		rchk(16'h03c2, {1'b1, ex[2:0], 4'h0});
		int_disable = 1'b1;
		idle(1);
		rchk(16'h03c2, {1'b0, ex[2:0], 4'h0});
		int_disable = 1'b0;
		int_clear_n = 1'b0;
		idle(4);
		rchk(16'h03c2, {1'b0, ex[2:0], 4'h0});
		int_clear_n = 1'b1;
		for (int i = 0; i < 16; i++) begin
			ex = rnd();
			s = rnd();
			{vretrace_in, display_active_in, crtc_color_sel} = ex[2:0];
			{wide_color_mux_enable, color_plane_diag_select} = i[2:0];
			video_output_pins = s;
			atc_nibble_mux_in = ~s;
			idle(3);
			rchk(ex[0] ? 16'h03da : 16'h03ba, stat_exp(ex[2], ex[1], i[1:0], i[2] ? ~s : s));
		end
		vsp_host_model_inst.rd(16'h0300, d, v);
		chk({v, d}, 9'h000);
		ex = rnd() & 8'hfe;
		vsp_host_model_inst.wr(16'h03c8, ex);
		for (int k = 0; k < 6; k++) begin
			pb[k] = rnd();
			vsp_host_model_inst.wr(16'h03c9, pb[k]);
		end
		e0 = {pb[0][5:0], pb[1][5:0], pb[2][5:0]};
		e1 = {pb[3][5:0], pb[4][5:0], pb[5][5:0]};
		rchk(16'h03c7, 8'h01);
		rchk(16'h03c8, ex + 8'h02);
		vsp_host_model_inst.wr(16'h03c7, ex);
		rchk(16'h03c7, 8'h03);
		vsp_host_model_inst.rd(16'h03c9, d, v);
		vsp_host_model_inst.wr(16'h03c7, ex);
		vsp_host_model_inst.rd3(e);
		chk(e, e0);
		vsp_host_model_inst.rd3(e);
		chk(e, e1);
		rchk(16'h03c8, ex + 8'h03);
		vsp_host_model_inst.wr(16'h03c6, 8'hfe);
		rchk(16'h03c6, 8'hfe);
		rchk(16'h03c7, 8'h02);
		video_output_pins = ex + 8'h01;
		idle(8);
		chk(palette_rgb, e0);
		complete_run();
	end
endmodule
